/* File: slrc_link_config.v */
`timescale 1ns/1ps
`include "slrc_defs.vh"

// Notes on behaviour
// R01 - Lane field bits 4:0 hold lanes per link minus one.
// R02 - Lane register bit 7 turns descrambling of received lanes on.
// R03 - Software writes octets-per-frame minus one and plain value separately.
// R04 - Multiframe field holds frames per multiframe minus one, 16 or 32.
// R05 - Converter register holds converters per link minus one, all bits.
// R06 - Resolution register: control bits zero, resolution minus one 0x0F.
// R07 - Packing field must be sixteen minus one in every mode.
// R08 - Samples field holds samples per converter per frame minus one.
// R09 - Dense packing set only for one octet per frame; control words zero.
// R10 - Device identity must equal the transmitter's device identity.
// R11 - Bank identity must equal the transmitter's bank identity.
// R12 - Lane zero identity must equal the transmitter's lane identity.
// R13 - Version field matches transmitter; 0 older, 1 newer standard.
// R14 - Subclass field bits 7:5 select subclass 0 or 1.
// R15 - Link-mode bit selects dual link; second link copies the first.
// R16 - Link-page bit steers parameter writes to the second link.
// R17 - Modes 8 to 13 single link, only 8 to 10 dual link.
// R18 - Sync-buffer bit 0 powers down the second link sync output.
// R19 - Status bit 3 flags bad lane combination, bit 2 bad multiframe.
// R20 - Status bit 5 flags bad clock delay, bit 1 bad subclass.
// R21 - Deskew mask bit set for each used logical lane.
// R22 - Lane enable mask bit set for each used lane before capture.
module slrc_link_config
(
  input wire CLOCK,
  input wire RST_N,
  input wire SCLK,
  input wire SDI,
  input wire CS_N,
  output wire SDO,
  output wire SDO_OE,
  output reg DUAL_LINK,
  output reg SECOND_LINK_SYNC_PD,
  output reg [4:0] LANE_COUNT_M1,
  output reg DESCRAMBLE_EN,
  output reg [4:0] FRAMES_PER_MF_M1,
  output reg [7:0] CONVERTERS_M1,
  output reg [4:0] SAMPLES_PER_FRAME_M1,
  output reg [2:0] SUBCLASS,
  output reg [7:0] DESKEW_MASK,
  output reg [7:0] LANE_ENABLE_MASK,
  output reg [7:0] CONFIG_STATUS
);

  // ****************************************************************
  // Slot numbering of the per-link parameter set
  // ****************************************************************
  localparam [3:0] S_DID = 4'h0;
  localparam [3:0] S_BID = 4'h1;
  localparam [3:0] S_LID = 4'h2;
  localparam [3:0] S_LANES = 4'h3;
  localparam [3:0] S_FM1 = 4'h4;
  localparam [3:0] S_KM1 = 4'h5;
  localparam [3:0] S_MM1 = 4'h6;
  localparam [3:0] S_RES = 4'h7;
  localparam [3:0] S_NP = 4'h8;
  localparam [3:0] S_VS = 4'h9;
  localparam [3:0] S_HD = 4'hA;
  localparam [3:0] S_DESKEW = 4'hB;
  localparam [3:0] S_F = 4'hC;
  localparam [3:0] S_LANE_EN = 4'hD;
  localparam [3:0] S_NONE = 4'hF;

  wire [14:0] addr;
  wire [7:0] wdata;
  wire wr;
  reg [7:0] rd_data;
  reg [7:0] par_r [0:2*`SLRC_SLOTS-1];
  reg [7:0] sync_pwr_r;
  reg [7:0] link_mode_r;
  reg [7:0] mf_delay_r;
  reg [3:0] slot;
  reg [4:0] wr_idx;
  reg [4:0] rd_idx;
  reg [7:0] status_nxt;
  wire [3:0] flags0;
  wire [3:0] flags1;
  integer i;

  // ****************************************************************
  // Serial register port
  // ****************************************************************
  slrc_spi_port u_port
  (
    .clk(CLOCK),
    .rst_n(RST_N),
    .sclk_pin(SCLK),
    .sdi_pin(SDI),
    .cs_n_pin(CS_N),
    .rd_data(rd_data),
    .addr_r(addr),
    .wdata_r(wdata),
    .wr_r(wr),
    .sdo_r(SDO),
    .sdo_oe_r(SDO_OE)
  );

  // ****************************************************************
  // Address decode
  // ****************************************************************
  function [3:0] slot_of;
    input [14:0] a;
    begin
      case (a)
        `SLRC_OFS_DID: slot_of = S_DID;
        `SLRC_OFS_BID: slot_of = S_BID;
        `SLRC_OFS_LANE_ZERO_IDENTITY: slot_of = S_LID;
        `SLRC_OFS_LANES: slot_of = S_LANES;
        `SLRC_OFS_FM1: slot_of = S_FM1;
        `SLRC_OFS_KM1: slot_of = S_KM1;
        `SLRC_OFS_MM1: slot_of = S_MM1;
        `SLRC_OFS_RES: slot_of = S_RES;
        `SLRC_OFS_NP: slot_of = S_NP;
        `SLRC_OFS_VS: slot_of = S_VS;
        `SLRC_OFS_HD: slot_of = S_HD;
        `SLRC_OFS_DESKEW: slot_of = S_DESKEW;
        `SLRC_OFS_F: slot_of = S_F;
        `SLRC_OFS_LANE_EN: slot_of = S_LANE_EN;
        default: slot_of = S_NONE;
      endcase
    end
  endfunction

  // Bits that exist in each slot; the rest read as zero
  function [7:0] mask_of;
    input [3:0] s;
    begin
      case (s)
        S_BID: mask_of = 8'h0F; // [R11]
        S_LID: mask_of = 8'h1F; // [R12]
        S_LANES: mask_of = 8'h9F; // [R01] [R02]
        S_KM1: mask_of = 8'h1F; // [R04]
        default: mask_of = 8'hFF;
      endcase
    end
  endfunction

  // ****************************************************************
  // Link page steering
  // ****************************************************************
  always @*
  begin
    slot = slot_of(addr);
    // Page bit picks the link that a parameter access reaches
    if (link_mode_r[`SLRC_LINK_PAGE_BIT])
      wr_idx = `SLRC_LINK1_BASE + {1'b0, slot}; // [R16]
    else
      wr_idx = {1'b0, slot};
    rd_idx = wr_idx;
  end

  // ****************************************************************
  // Register writes
  // ****************************************************************
  always @(posedge CLOCK)
  begin
    if (!RST_N)
    begin
      for (i = 0; i < 2*`SLRC_SLOTS; i = i + 1)
        par_r[i] <= `SLRC_RST_BYTE;
      sync_pwr_r <= `SLRC_RST_BYTE;
      link_mode_r <= `SLRC_RST_BYTE;
      mf_delay_r <= `SLRC_RST_BYTE;
    end
    else if (wr)
    begin
      if (slot != S_NONE)
        par_r[wr_idx] <= wdata & mask_of(slot); // [R03] [R13] [R16]
      else if (addr == `SLRC_OFS_SYNC_PWR)
        sync_pwr_r <= wdata & 8'h01; // [R18]
      else if (addr == `SLRC_OFS_LINK_MODE)
        link_mode_r <= wdata & 8'h0C; // [R15] [R16]
      else if (addr == `SLRC_OFS_MF_DELAY)
        mf_delay_r <= wdata & 8'h1F;
    end
  end

  // ****************************************************************
  // Register reads; unmapped offsets read zero
  // ****************************************************************
  always @*
  begin
    if (slot != S_NONE)
      rd_data = par_r[rd_idx];
    else if (addr == `SLRC_OFS_STATUS)
      rd_data = CONFIG_STATUS;
    else if (addr == `SLRC_OFS_SYNC_PWR)
      rd_data = sync_pwr_r;
    else if (addr == `SLRC_OFS_LINK_MODE)
      rd_data = link_mode_r;
    else if (addr == `SLRC_OFS_MF_DELAY)
      rd_data = mf_delay_r;
    else
      rd_data = 8'h00;
  end

  // ****************************************************************
  // Configuration checks, one per link
  // ****************************************************************
  // Flag order: {delay, combination, multiframe, subclass}
  function [3:0] check;
    input [7:0] lanes;
    input [7:0] fm1;
    input [7:0] km1;
    input [7:0] mm1;
    input [7:0] np;
    input [7:0] vs;
    input [7:0] dly;
    reg combo_ok;
    reg k_ok;
    begin
      // Receive-side settings of modes 8-13 collapse onto three sets,
      // keyed by {lanes, octets, samples}, each minus one
      case ({lanes[4:0], fm1, vs[4:0]})
        18'h06001: combo_ok = (mm1 == 8'h00);
        18'h02000: combo_ok = (mm1 == 8'h00);
        18'h00020: combo_ok = (mm1 == 8'h00);
        default: combo_ok = 1'b0;
      endcase
      // One octet per frame needs 32 frames; two octets allow 16 or 32
      case (km1[4:0])
        `SLRC_K32_M1: k_ok = 1'b1; // [R04]
        `SLRC_K16_M1: k_ok = (fm1 != 8'h00); // [R04]
        default: k_ok = 1'b0;
      endcase
      check[3] = dly[4:0] > km1[4:0]; // [R20]
      check[2] = ~combo_ok; // [R19] [R01] [R05] [R08]
      check[1] = ~k_ok; // [R19]
      check[0] = np[7:5] > `SLRC_SUBCLASS_MAX; // [R20] [R14]
    end
  endfunction

  // ****************************************************************
  // Per-link checks
  // ****************************************************************
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1)
    begin : g_chk
      wire [3:0] f;
      assign f = check(par_r[g*`SLRC_SLOTS+S_LANES],
        par_r[g*`SLRC_SLOTS+S_FM1], par_r[g*`SLRC_SLOTS+S_KM1],
        par_r[g*`SLRC_SLOTS+S_MM1], par_r[g*`SLRC_SLOTS+S_NP],
        par_r[g*`SLRC_SLOTS+S_VS], mf_delay_r);
    end
  endgenerate

  assign flags0 = g_chk[0].f;
  // Second link only counts when dual link is on; modes 11-13 have
  // single-link receive settings identical to 8-10
  assign flags1 = link_mode_r[`SLRC_LINK_MODE_BIT] ?
    g_chk[1].f : 4'h0; // [R15] [R17]

  // ****************************************************************
  // Status assembly
  // ****************************************************************
  always @*
  begin
    status_nxt = 8'h00;
    status_nxt[`SLRC_ST_DELAY_BIT] = flags0[3] | flags1[3]; // [R20]
    status_nxt[`SLRC_ST_COMBO_BIT] = flags0[2] | flags1[2]; // [R19]
    status_nxt[`SLRC_ST_K_BIT] = flags0[1] | flags1[1]; // [R19]
    status_nxt[`SLRC_ST_SUBCLASS_BIT] = flags0[0] | flags1[0]; // [R20]
  end

  // ****************************************************************
  // Registered outputs of the first link and global controls
  // ****************************************************************
  always @(posedge CLOCK)
  begin
    if (!RST_N)
    begin
      DUAL_LINK <= 1'b0;
      SECOND_LINK_SYNC_PD <= 1'b0;
      LANE_COUNT_M1 <= 5'h00;
      DESCRAMBLE_EN <= 1'b0;
      FRAMES_PER_MF_M1 <= 5'h00;
      CONVERTERS_M1 <= 8'h00;
      SAMPLES_PER_FRAME_M1 <= 5'h00;
      SUBCLASS <= 3'h0;
      DESKEW_MASK <= 8'h00;
      LANE_ENABLE_MASK <= 8'h00;
      CONFIG_STATUS <= 8'h00;
    end
    else
    begin
      DUAL_LINK <= link_mode_r[`SLRC_LINK_MODE_BIT]; // [R15]
      SECOND_LINK_SYNC_PD <= sync_pwr_r[`SLRC_SYNC_PD_BIT]; // [R18]
      LANE_COUNT_M1 <= par_r[S_LANES][4:0]; // [R01]
      DESCRAMBLE_EN <= par_r[S_LANES][`SLRC_SCRAMBLE_BIT]; // [R02]
      FRAMES_PER_MF_M1 <= par_r[S_KM1][4:0]; // [R04]
      CONVERTERS_M1 <= par_r[S_MM1]; // [R05]
      SAMPLES_PER_FRAME_M1 <= par_r[S_VS][4:0]; // [R08]
      SUBCLASS <= par_r[S_NP][7:5]; // [R14]
      DESKEW_MASK <= par_r[S_DESKEW];
      LANE_ENABLE_MASK <= par_r[S_LANE_EN];
      CONFIG_STATUS <= status_nxt; // [R19] [R20]
    end
  end

endmodule

/* File: slrc_defs.vh */
`ifndef SLRC_DEFS_VH
`define SLRC_DEFS_VH

// ****************************************************************
// Serial port framing
// ****************************************************************
`define SLRC_ADDR_W 15
`define SLRC_INSTR_BITS 5'd16
`define SLRC_FRAME_BITS 5'd24

// ****************************************************************
// Register offsets
// ****************************************************************
`define SLRC_OFS_STATUS 15'h0030
`define SLRC_OFS_SYNC_PWR 15'h0203
`define SLRC_OFS_LINK_MODE 15'h0300
`define SLRC_OFS_MF_DELAY 15'h0304
`define SLRC_OFS_DID 15'h0450
`define SLRC_OFS_BID 15'h0451
`define SLRC_OFS_LANE_ZERO_IDENTITY 15'h0452
`define SLRC_OFS_LANES 15'h0453
`define SLRC_OFS_FM1 15'h0454
`define SLRC_OFS_KM1 15'h0455
`define SLRC_OFS_MM1 15'h0456
`define SLRC_OFS_RES 15'h0457
`define SLRC_OFS_NP 15'h0458
`define SLRC_OFS_VS 15'h0459
`define SLRC_OFS_HD 15'h045A
`define SLRC_OFS_DESKEW 15'h046C
`define SLRC_OFS_F 15'h0476
`define SLRC_OFS_LANE_EN 15'h047D

// ****************************************************************
// Field positions
// ****************************************************************
`define SLRC_LINK_MODE_BIT 3
`define SLRC_LINK_PAGE_BIT 2
`define SLRC_SYNC_PD_BIT 0
`define SLRC_SCRAMBLE_BIT 7
`define SLRC_ST_DELAY_BIT 5
`define SLRC_ST_COMBO_BIT 3
`define SLRC_ST_K_BIT 2
`define SLRC_ST_SUBCLASS_BIT 1

// ****************************************************************
// Parameter slots per link, reset values and check limits
// ****************************************************************
`define SLRC_SLOTS 14
`define SLRC_LINK1_BASE 5'h0E
`define SLRC_RST_BYTE 8'h00
`define SLRC_K32_M1 5'h1F
`define SLRC_K16_M1 5'h0F
`define SLRC_SUBCLASS_MAX 3'h1

`endif

/* File: slrc_spi_port.v */
`timescale 1ns/1ps
`include "slrc_defs.vh"

// Serial register port: 16-bit instruction (read flag, 15-bit address),
// then one data byte, MSB first. Pins are oversampled by CLOCK.
module slrc_spi_port
(
  input wire clk,
  input wire rst_n,
  input wire sclk_pin,
  input wire sdi_pin,
  input wire cs_n_pin,
  input wire [7:0] rd_data,
  output reg [14:0] addr_r,
  output reg [7:0] wdata_r,
  output reg wr_r,
  output reg sdo_r,
  output reg sdo_oe_r
);

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  reg [2:0] meta_r;
  reg [2:0] sync_r;
  reg sclk_d_r;
  reg [4:0] cnt_r;
  reg [15:0] sh_r;
  reg read_r;
  reg [7:0] out_r;
  wire sclk_s;
  wire sdi_s;
  wire cs_n_s;
  wire rise;
  wire fall;

  assign sclk_s = sync_r[2];
  assign sdi_s = sync_r[1];
  assign cs_n_s = sync_r[0];
  assign rise = sclk_s & ~sclk_d_r & ~cs_n_s;
  assign fall = ~sclk_s & sclk_d_r & ~cs_n_s;

  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      meta_r <= 3'h1;
      sync_r <= 3'h1;
      sclk_d_r <= 1'b0;
    end
    else
    begin
      meta_r <= {sclk_pin, sdi_pin, cs_n_pin};
      sync_r <= meta_r;
      sclk_d_r <= sclk_s;
    end
  end

  // ****************************************************************
  // Shifting and access strobes
  // ****************************************************************
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      cnt_r <= 5'h00;
      sh_r <= 16'h0000;
      read_r <= 1'b0;
      out_r <= 8'h00;
      addr_r <= 15'h0000;
      wdata_r <= 8'h00;
      wr_r <= 1'b0;
      sdo_r <= 1'b0;
      sdo_oe_r <= 1'b0;
    end
    else
    begin
      wr_r <= 1'b0;
      if (cs_n_s)
      begin
        cnt_r <= 5'h00;
        read_r <= 1'b0;
        sdo_oe_r <= 1'b0;
      end
      else
      begin
        if (rise && cnt_r < `SLRC_FRAME_BITS)
        begin
          sh_r <= {sh_r[14:0], sdi_s};
          cnt_r <= cnt_r + 5'h01;
          if (cnt_r == `SLRC_INSTR_BITS - 5'h01)
          begin
            read_r <= sh_r[14];
            addr_r <= {sh_r[13:0], sdi_s};
          end
          if (cnt_r == `SLRC_FRAME_BITS - 5'h01 && !read_r)
          begin
            wdata_r <= {sh_r[6:0], sdi_s};
            wr_r <= 1'b1;
          end
        end
        if (fall && read_r && cnt_r == `SLRC_INSTR_BITS)
        begin
          sdo_r <= rd_data[7];
          out_r <= {rd_data[6:0], 1'b0};
          sdo_oe_r <= 1'b1;
        end
        else if (fall && read_r && cnt_r > `SLRC_INSTR_BITS)
        begin
          sdo_r <= out_r[7];
          out_r <= {out_r[6:0], 1'b0};
        end
      end
    end
  end

endmodule

/* File: slrc_spi_host.sv */
`timescale 1ns/1ps
module slrc_spi_host
(
  input wire clk,
  input wire sdo,
  input wire sdo_oe,
  output logic sclk,
  output logic sdi,
  output logic cs_n
);
  // ****************************************************************
  // Serial register host
  // ****************************************************************
  initial
  begin
    sclk = 1'h0;
    sdi = 1'h0;
    cs_n = 1'h1;
  end

  task automatic half();
    repeat (8) @(posedge clk);
    #1;
  endtask

  // One frame: read flag, 15-bit address, one byte, MSB first
  task automatic xfer(input logic rd, input logic [14:0] a,
    input logic [7:0] wd, output logic [7:0] rdat);
    logic [23:0] f;
    f = {rd, a, wd};
    rdat = 8'h00;
    @(posedge clk);
    #1;
    cs_n = 1'h0;
    for (int i = 23; i >= 0; i--)
    begin
      sdi = f[i];
      half();
      sclk = 1'h1;
      if (rd && i < 8)
        rdat[i] = sdo_oe ? sdo : 1'hx;
      half();
      sclk = 1'h0;
    end
    // Released data line shows no stale bit
    sdi = ~sdi;
    half();
    cs_n = 1'h1;
    half();
  endtask
endmodule

/* File: slrc_link_config_chk.sv */
`timescale 1ns/1ps
module slrc_link_config_chk
(
  input wire CLOCK,
  input wire RST_N,
  input wire SCLK,
  input wire CS_N,
  input wire SDO,
  input wire SDO_OE,
  input wire DUAL_LINK,
  input wire SECOND_LINK_SYNC_PD,
  input wire [4:0] LANE_COUNT_M1,
  input wire DESCRAMBLE_EN,
  input wire [4:0] FRAMES_PER_MF_M1,
  input wire [7:0] CONVERTERS_M1,
  input wire [4:0] SAMPLES_PER_FRAME_M1,
  input wire [2:0] SUBCLASS,
  input wire [7:0] CONFIG_STATUS
);
  // ****************************************************************
  // Helper state and properties
  // ****************************************************************
  reg [2:0] up_r;
  reg [3:0] cs_hi_r;
  wire [9:0] ls = {LANE_COUNT_M1, SAMPLES_PER_FRAME_M1};
  // Lane and sample pair that some legal combination could match
  wire combo_ok = CONVERTERS_M1 == 8'h00 &&
    (ls == 10'h061 || ls == 10'h020 || ls == 10'h000);

  always @(posedge CLOCK)
  begin
    up_r <= RST_N ? {up_r[1:0], 1'h1} : 3'h0;
    if (!RST_N || !CS_N)
      cs_hi_r <= 4'h0;
    else if (cs_hi_r != 4'hF)
      cs_hi_r <= cs_hi_r + 4'h1;
  end

  default clocking dc @(posedge CLOCK);
  endclocking
  default disable iff (!RST_N);

  sequence s_cs_idle;
    CS_N [*6];
  endsequence
  sequence s_sdo_held;
    (SCLK && SDO_OE) [*7];
  endsequence

  rst_clear_a: assert property (
    $rose(RST_N) |-> CONFIG_STATUS == 8'h00 && !DUAL_LINK)
    else $error("status or link mode not clear after reset");
  k_legal_a: assert property (
    up_r[2] && FRAMES_PER_MF_M1 == 5'h1F && !DUAL_LINK &&
    $stable({FRAMES_PER_MF_M1, DUAL_LINK}) |-> !CONFIG_STATUS[2])
    else $error("multiframe flag set for 32 frames");
  k_bad_a: assert property (
    up_r[2] && FRAMES_PER_MF_M1 != 5'h1F && FRAMES_PER_MF_M1 != 5'h0F &&
    $stable(FRAMES_PER_MF_M1) |-> CONFIG_STATUS[2])
    else $error("multiframe flag clear for illegal length");
  sub_bad_a: assert property (
    up_r[2] && SUBCLASS > 3'h1 && $stable(SUBCLASS) |-> CONFIG_STATUS[1])
    else $error("subclass flag clear for illegal subclass");
  sub_ok_a: assert property (
    up_r[2] && SUBCLASS < 3'h2 && !DUAL_LINK &&
    $stable({SUBCLASS, DUAL_LINK}) |-> !CONFIG_STATUS[1])
    else $error("subclass flag set for legal subclass");
  combo_bad_a: assert property (
    up_r[2] && !combo_ok && $stable({ls, CONVERTERS_M1}) |->
    CONFIG_STATUS[3])
    else $error("combination flag clear for unsupported set");
  sdo_off_a: assert property (
    s_cs_idle |-> !SDO_OE)
    else $error("read data driven without select");
  sdo_hold_a: assert property (
    s_sdo_held |-> $stable(SDO))
    else $error("read data moved while serial clock high");
  cfg_quiet_a: assert property (
    $changed({DUAL_LINK, SECOND_LINK_SYNC_PD, DESCRAMBLE_EN, LANE_COUNT_M1})
    |-> cs_hi_r < 4'h8)
    else $error("configuration changed with no frame");
endmodule

bind slrc_link_config slrc_link_config_chk slrc_link_config_chk_i (
  .CLOCK(CLOCK), .RST_N(RST_N), .SCLK(SCLK), .CS_N(CS_N), .SDO(SDO),
  .SDO_OE(SDO_OE), .DUAL_LINK(DUAL_LINK),
  .SECOND_LINK_SYNC_PD(SECOND_LINK_SYNC_PD), .LANE_COUNT_M1(LANE_COUNT_M1),
  .DESCRAMBLE_EN(DESCRAMBLE_EN), .FRAMES_PER_MF_M1(FRAMES_PER_MF_M1),
  .CONVERTERS_M1(CONVERTERS_M1), .SAMPLES_PER_FRAME_M1(SAMPLES_PER_FRAME_M1),
  .SUBCLASS(SUBCLASS), .CONFIG_STATUS(CONFIG_STATUS));

/* File: serial_link_rx_config_tb_top.sv */
`timescale 1ns/1ps
module serial_link_rx_config_tb_top;
  // ****************************************************************
  // Bench
  // ****************************************************************
  logic CLOCK, RST_N, SCLK, SDI, CS_N, SDO, SDO_OE, DUAL, SPD, DSC;
  logic [4:0] LANES, KM1, SM1;
  logic [2:0] SUBC;
  logic [7:0] MM1, DSK, LEN, STAT, rd, lr, fm, kr, mr, np, vs, dl, dk, le, d;
  logic [31:0] b;
  logic [14:0] a;
  logic dual, page, spd;
  int bad_count = 0;
  int compares = 0;
  integer seed = 32'h2AE1;
  logic [14:0] ma [0:10] = '{15'h453, 15'h454, 15'h455, 15'h456, 15'h457,
    15'h458, 15'h459, 15'h45A, 15'h46C, 15'h476, 15'h47D};
  // Mode settings 8 to 12 in address order
  logic [87:0] mt [0:4] = '{88'h03001F000F0F21800F010F,
    88'h01001F000F0F2080030103, 88'h00011F000F0F2000010201,
    88'h03001F000F0F2180FF01FF, 88'h01001F000F0F2080330133};
  logic [22:0] cn [0:4] = '{23'h4550F, 23'h4550A, 23'h4584F, 23'h45302,
    23'h3041F};

  slrc_link_config slrc_link_config_i (.CLOCK(CLOCK), .RST_N(RST_N),
    .SCLK(SCLK), .SDI(SDI), .CS_N(CS_N), .SDO(SDO), .SDO_OE(SDO_OE),
    .DUAL_LINK(DUAL), .SECOND_LINK_SYNC_PD(SPD), .LANE_COUNT_M1(LANES),
    .DESCRAMBLE_EN(DSC), .FRAMES_PER_MF_M1(KM1), .CONVERTERS_M1(MM1),
    .SAMPLES_PER_FRAME_M1(SM1), .SUBCLASS(SUBC), .DESKEW_MASK(DSK),
    .LANE_ENABLE_MASK(LEN), .CONFIG_STATUS(STAT));
  slrc_spi_host slrc_spi_host_i (.clk(CLOCK), .sdo(SDO), .sdo_oe(SDO_OE),
    .sclk(SCLK), .sdi(SDI), .cs_n(CS_N));

  initial
  begin
    CLOCK = 1'h0;
    forever #2 CLOCK = ~CLOCK;
  end

  task automatic chk(input string n, input logic [7:0] seen, exp);
    compares++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("Error %s expected %h seen %h", n, exp, seen);
    end
  endtask

  function automatic logic [7:0] exp_st(input logic [7:0] x);
    logic [17:0] c;
    logic ok;
    c = {lr[4:0], fm, vs[4:0]};
    ok = mr == 8'h00 && (c == 18'h06001 || c == 18'h02000 || c == 18'h00020);
    return x | {2'h0, dl[4:0] > kr[4:0], 1'h0, !ok,
      !(kr == 8'h1F || kr == 8'h0F && fm != 8'h00), np[7:5] > 3'h1, 1'h0};
  endfunction

  task automatic wr(input logic [14:0] wa, input logic [7:0] v);
    slrc_spi_host_i.xfer(1'h0, wa, v, rd);
    if (wa == 15'h300)
      {dual, page} = v[3:2];
    if (wa == 15'h203)
      spd = v[0];
    if (wa == 15'h304)
      dl = v & 8'h1F;
    if (!page)
      case (wa)
        15'h453: lr = v & 8'h9F;
        15'h454: fm = v;
        15'h455: kr = v & 8'h1F;
        15'h456: mr = v;
        15'h458: np = v;
        15'h459: vs = v;
        15'h46C: dk = v;
        15'h47D: le = v;
        default: ;
      endcase
  endtask

  task automatic rdc(input logic [14:0] ra, input logic [7:0] e);
    slrc_spi_host_i.xfer(1'h1, ra, 8'h00, rd);
    chk("readback", rd, e);
  endtask

  task automatic outs(input logic [7:0] x);
    chk("lanes", LANES, lr[4:0]);
    chk("descramble", DSC, lr[7]);
    chk("frames", KM1, kr[4:0]);
    chk("converters", MM1, mr);
    chk("samples", SM1, vs[4:0]);
    chk("subclass", SUBC, np[7:5]);
    chk("deskew", DSK, dk);
    chk("lane_en", LEN, le);
    chk("dual", DUAL, dual);
    chk("sync_pd", SPD, spd);
    chk("status", STAT, exp_st(x));
  endtask

  task automatic test_done();
    $display("Compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial
  begin
    repeat (100000) @(posedge CLOCK);
    bad_count++;
    test_done();
  end

  initial
  begin
    RST_N = 1'h0;
    {lr, fm, kr, mr, np, vs, dl, dk, le, dual, page, spd} = '0;
    repeat (10) @(posedge CLOCK);
    #1;
    RST_N = 1'h1;
    repeat (4) @(posedge CLOCK);
    #1;
    outs(8'h00);
    for (int i = 0; i < 5; i++)
    begin
      b = $random(seed);
      for (int p = (i < 3) ? 0 : 1; p < 2; p++)
      begin
        wr(15'h300, p ? (i < 3 ? 8'h08 : 8'h00) : 8'h04);
        for (int j = 0; j < 11; j++)
        begin
          d = mt[i][87 - 8 * j -: 8];
          d[7] = (j == 0) ? b[0] : d[7];
          d[5] = (j == 5) ? b[1] : d[5];
          d[4] = (j == 2 && i == 2) ? b[2] : d[4];
          wr(ma[j], d);
        end
      end
      outs(8'h00);
    end
    // Second link alone gets a bad length, then joins
    wr(15'h300, 8'h04);
    wr(15'h455, 8'h0A);
    rdc(15'h455, 8'h0A);
    wr(15'h300, 8'h0C);
    outs(8'h04);
    wr(15'h300, 8'h00);
    for (int i = 0; i < 5; i++)
    begin
      {a, d} = cn[i];
      wr(a, d);
      outs(8'h00);
    end
    rdc(15'h030, exp_st(8'h00));
    wr(15'h030, 8'h00);
    rdc(15'h030, exp_st(8'h00));
    rdc(15'h100, 8'h00);
    rdc(15'h304, dl);
    wr(15'h203, 8'h01);
    outs(8'h00);
    rdc(15'h203, 8'h01);
    for (int i = 0; i < 3; i++)
    begin
      d = 8'($random(seed)) & (i == 0 ? 8'hFF : i == 1 ? 8'h0F : 8'h1F);
      wr(15'h450 + 15'(i), d);
      rdc(15'h450 + 15'(i), d);
    end
    // Reset in mid-run with dual link and sync power-down on
    wr(15'h300, 8'h08);
    RST_N = 1'h0;
    {lr, fm, kr, mr, np, vs, dl, dk, le, dual, page, spd} = '0;
    repeat (3) @(posedge CLOCK);
    #1;
    RST_N = 1'h1;
    repeat (4) @(posedge CLOCK);
    #1;
    outs(8'h00);
    test_done();
  end
endmodule
